// file: hw/lsc_top.sv
// Latching scaler core: counters, triggers, event buffer, APB slave
//
// Our own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
module lsc_top
  import lsc_pkg::*;
#(
  parameter bit          BUFFERED          = 1'b1,
  parameter int unsigned EVENT_WORDS       = BUF_WORDS,
  parameter int unsigned LED_INIT_CYCLES   = LED_INIT_CYC,
  parameter int unsigned LED_ACCESS_CYCLES = LED_ACC_CYC
)(
  // Clock and reset
  input  logic                sys_clk,
  input  logic                rst,
  // Register bus
  input  lsc_apb_req_t        apb_req,
  output lsc_apb_rsp_t        apb_rsp,
  // Detector and control inputs
  input  logic [NUM_CH-1:0]   channel_in,
  input  logic                test_in,
  input  logic                counter_clear_input,
  input  logic                count_inhibit_input,
  input  logic                trigger_input_front,
  input  logic                trigger_input_bus,
  // Wired-OR control lines
  input  logic                data_ready_line_i,
  output logic                data_ready_line_o,
  output logic                data_ready_line_oe,
  input  logic                busy_line_i,
  output logic                busy_line_o,
  output logic                busy_line_oe,
  // Indicators
  output logic                buffer_full,
  output logic                led_access,
  output logic                led_ready,
  output logic                led_busy,
  output logic                led_full
);

  localparam int unsigned ROWS = EVENT_WORDS / NUM_CH;
  localparam int unsigned RAW  = $clog2(ROWS);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [1:0]               acq;
    logic                     clr_buf;
    logic [31:0]              ch_en;
    logic [31:0]              dwell;
    logic [NUM_CH-1:0][31:0]  cnt;
    logic [NUM_CH-1:0][31:0]  lat;
    logic [NUM_CH-1:0]        ch_prev;
    logic                     test_prev;
    logic                     trg_prev;
    logic [3:0]               busy_cnt;
    logic [1:0]               step;
    logic [31:0]              tick;
    logic [15:0]              trig_num;
    logic [RAW-1:0]           wr_ptr;
    logic [RAW-1:0]           rd_ptr;
    logic [RAW:0]             fill;
    logic [5:0]               rd_word;
    lsc_apb_rsp_t             rsp;
    logic                     ready;
    logic                     busy;
    logic                     full;
    logic                     led_acc;
    logic                     led_rdy;
    logic                     led_bsy;
    logic                     led_ful;
    logic [23:0]              init_cnt;
    logic [23:0]              acc_cnt;
  } lsc_state_t;

  lsc_state_t s_q;
  lsc_state_t s_d;

  // Row-wide storage; one write per event keeps busy fixed
  logic [NUM_CH-1:0][31:0] dat_mem [ROWS];
  logic [31:0]             hdr_mem [ROWS];
  logic [31:0]             msk_mem [ROWS];

  logic                    acc_phase;
  logic                    done;
  logic                    hit;
  logic [31:0]             rdata;
  logic [31:0]             buf_word;
  logic                    sw_trg;
  logic                    sw_clr;
  logic                    clear_now;
  logic                    pop;
  logic                    test_rise;
  logic                    ext_trg;
  logic                    ext_fall;
  logic                    tmr_step;
  logic                    tmr_fire;
  logic                    trg_req;
  lsc_src_t                src;
  logic                    accept;
  logic                    wr_en;
  logic [RAW-1:0]          wr_addr;
  logic [31:0]             hdr_w;
  logic [5:0]              nx;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [5:0] ones(input logic [31:0] m);
    logic [5:0] n;
    n = 6'd0;
    for (int i = 0; i < 32; i++)
    begin
      n = n + 6'(m[i]);
    end
    return n;
  endfunction

  function automatic logic [5:0] next_en(input logic [31:0] m, input logic [5:0] from);
    logic [5:0] r;
    r = 6'd32;
    for (int i = 31; i >= 0; i--)
    begin
      if (m[i] && 6'(i) >= from)
        r = 6'(i);
    end
    return r;
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    s_d       = s_q;
    wr_en     = 1'b0;
    hdr_w     = 32'h0000_0000;
    nx        = 6'd32;
    acc_phase = apb_req.psel & apb_req.penable;
    done      = acc_phase & s_q.rsp.pready;

    // Read side of the buffer
    if (s_q.rd_word == 6'd0)
      buf_word = hdr_mem[s_q.rd_ptr];
    else
      buf_word = dat_mem[s_q.rd_ptr][5'(s_q.rd_word - 6'd1)];

    // Address decode
    hit   = 1'b1;
    rdata = 32'h0000_0000;
    if (apb_req.paddr[15:7] == OFS_CNT_PG)
      rdata = s_q.lat[apb_req.paddr[6:2]];
    else
    begin
      case (apb_req.paddr)
        OFS_BUF:    rdata = (BUFFERED && s_q.fill != '0) ? buf_word : 32'h0000_0000;
        OFS_CHEN:   rdata = s_q.ch_en;
        OFS_DWELL:  rdata = s_q.dwell;
        OFS_CTRL:   rdata = {25'h000_0000, s_q.clr_buf, 4'h0, s_q.acq};
        OFS_STAT:   rdata = {27'h000_0000, busy_line_i, data_ready_line_i,
                             s_q.full, s_q.busy, s_q.ready};
        OFS_SWTRG:  rdata = 32'h0000_0000;
        OFS_SWCLR:  rdata = 32'h0000_0000;
        OFS_FILL:   rdata = 32'(s_q.fill);
        OFS_TRGNUM: rdata = {16'h0000, s_q.trig_num};
        default:    hit = 1'b0;
      endcase
    end

    // One wait state; reads leave the counters alone, so counting never stalls
    s_d.rsp.pready = acc_phase & ~s_q.rsp.pready;
    if (acc_phase && !s_q.rsp.pready)
    begin
      s_d.rsp.prdata  = apb_req.pwrite ? 32'h0000_0000 : rdata;
      s_d.rsp.pslverr = ~hit;
    end
    else
      s_d.rsp.pslverr = 1'b0;

    sw_trg = done & apb_req.pwrite & (apb_req.paddr == OFS_SWTRG);
    sw_clr = done & apb_req.pwrite & (apb_req.paddr == OFS_SWCLR);
    pop    = done & ~apb_req.pwrite & (apb_req.paddr == OFS_BUF)
             & BUFFERED & (s_q.fill != '0);

    if (done && apb_req.pwrite)
    begin
      case (apb_req.paddr)
        OFS_CHEN:  s_d.ch_en = apb_req.pwdata;
        OFS_DWELL: s_d.dwell = apb_req.pwdata;
        OFS_CTRL:
        begin
          s_d.acq     = apb_req.pwdata[1:0];
          s_d.clr_buf = apb_req.pwdata[CTRL_CLRBUF];
        end
        default:   s_d.acq = s_q.acq;
      endcase
    end

    // Counting
    clear_now     = counter_clear_input | sw_clr;
    test_rise     = test_in & ~s_q.test_prev;
    s_d.ch_prev   = channel_in;
    s_d.test_prev = test_in;
    for (int i = 0; i < NUM_CH; i++)
    begin
      if (clear_now)
        s_d.cnt[i] = 32'h0000_0000;
      else if (!count_inhibit_input && ((channel_in[i] && !s_q.ch_prev[i]) || test_rise))
        s_d.cnt[i] = s_q.cnt[i] + 32'h0000_0001;
    end

    // Dwell timer; step enable every 400 ns
    tmr_step = (s_q.step == STEP_LAST);
    s_d.step = tmr_step ? 2'b00 : s_q.step + 2'b01;
    tmr_fire = 1'b0;
    if (s_q.acq != ACQ_PERIODIC || s_q.dwell == 32'h0000_0000)
      s_d.tick = 32'h0000_0000;
    else if (tmr_step)
    begin
      // Period shorter than busy just loses ticks
      if (s_q.tick >= s_q.dwell - 32'h0000_0001)
      begin
        tmr_fire = 1'b1;
        s_d.tick = 32'h0000_0000;
      end
      else
        s_d.tick = s_q.tick + 32'h0000_0001;
    end

    // Trigger selection
    ext_trg      = trigger_input_front | trigger_input_bus;
    ext_fall     = s_q.trg_prev & ~ext_trg;
    s_d.trg_prev = ext_trg;
    case (s_q.acq)
      ACQ_RANDOM:
      begin
        trg_req = ext_fall | sw_trg;
        src     = ext_fall ? SRC_EXT : SRC_BUS;
      end
      ACQ_PERIODIC:
      begin
        trg_req = tmr_fire;
        src     = SRC_TIMER;
      end
      default:
      begin
        trg_req = 1'b0;
        src     = SRC_EXT;
      end
    endcase
    accept = trg_req & (s_q.busy_cnt == 4'h0) & ~(BUFFERED & s_q.full);

    if (accept)
    begin
      s_d.lat      = s_q.cnt;
      s_d.trig_num = s_q.trig_num + 16'h0001;
      s_d.busy_cnt = BUFFERED ? BUSY_BUF_CYC : BUSY_UNBUF_CYC;
      wr_en        = BUFFERED;
      hdr_w        = 32'h0000_0000;
      hdr_w[HDR_ID] = 1'b1;
      hdr_w[23:18] = ones(s_q.ch_en);
      hdr_w[17:16] = src;
      hdr_w[15:0]  = s_q.trig_num;
    end
    else if (s_q.busy_cnt != 4'h0)
      s_d.busy_cnt = s_q.busy_cnt - 4'h1;

    // Buffer pointers; clear beats a same-cycle pop
    if (clear_now && s_q.clr_buf)
    begin
      s_d.wr_ptr  = '0;
      s_d.rd_ptr  = '0;
      s_d.fill    = '0;
      s_d.rd_word = 6'd0;
    end
    else if (pop)
    begin
      nx = next_en(msk_mem[s_q.rd_ptr], s_q.rd_word);
      if (nx == 6'd32)
      begin
        s_d.rd_ptr  = s_q.rd_ptr + RAW'(1);
        s_d.fill    = s_q.fill - (RAW + 1)'(1);
        s_d.rd_word = 6'd0;
      end
      else
        s_d.rd_word = nx + 6'd1;
    end
    wr_addr = s_d.wr_ptr;
    if (wr_en)
    begin
      s_d.wr_ptr = s_d.wr_ptr + RAW'(1);
      s_d.fill   = s_d.fill + (RAW + 1)'(1);
    end

    // Status and wired-OR drive
    s_d.full  = BUFFERED & (s_d.fill == (RAW + 1)'(ROWS));
    s_d.ready = BUFFERED & (s_d.fill != '0);
    s_d.busy  = (s_d.busy_cnt != 4'h0) | s_d.full;

    // Indicators
    if (s_q.init_cnt != 24'h00_0000)
      s_d.init_cnt = s_q.init_cnt - 24'h00_0001;
    if (done)
      s_d.acc_cnt = 24'(LED_ACCESS_CYCLES);
    else if (s_q.acc_cnt != 24'h00_0000)
      s_d.acc_cnt = s_q.acc_cnt - 24'h00_0001;
    s_d.led_acc = (s_d.init_cnt != 24'h00_0000) | (s_d.acc_cnt != 24'h00_0000);
    s_d.led_rdy = (s_d.init_cnt != 24'h00_0000) | s_d.ready;
    s_d.led_bsy = (s_d.init_cnt != 24'h00_0000) | s_d.busy;
    s_d.led_ful = (s_d.init_cnt != 24'h00_0000) | s_d.full;
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      s_q          <= '0;
      s_q.ch_en    <= CHEN_RST;
      s_q.dwell    <= DWELL_RST;
      s_q.init_cnt <= 24'(LED_INIT_CYCLES);
    end
    else
      s_q <= s_d;
  end

  always_ff @(posedge sys_clk)
  begin
    if (wr_en)
    begin
      dat_mem[wr_addr] <= s_q.cnt;
      hdr_mem[wr_addr] <= hdr_w;
      msk_mem[wr_addr] <= s_q.ch_en;
    end
  end

  // Open-drain style: drive high only while asserted
  assign apb_rsp            = s_q.rsp;
  assign data_ready_line_o  = s_q.ready;
  assign data_ready_line_oe = s_q.ready;
  assign busy_line_o        = s_q.busy;
  assign busy_line_oe       = s_q.busy;
  assign buffer_full        = s_q.full;
  assign led_access         = s_q.led_acc;
  assign led_ready          = s_q.led_rdy;
  assign led_busy           = s_q.led_bsy;
  assign led_full           = s_q.led_ful;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  sequence s_step_gap;
    (!tmr_step) [*3] ##1 tmr_step;
  endsequence

  sequence s_busy_win;
    s_q.busy [*5] ##1 s_q.busy [*5];
  endsequence

  a_count_edge: assert property (channel_in[0] && !s_q.ch_prev[0] && !count_inhibit_input
      && !clear_now |=> s_q.cnt[0] == $past(s_q.cnt[0]) + 32'h0000_0001)
    else $error("channel 0 missed an edge");

  a_inhibit_hold: assert property (count_inhibit_input && !clear_now
      |=> s_q.cnt == $past(s_q.cnt))
    else $error("counter moved under inhibit");

  a_clear_zero: assert property (counter_clear_input |=> s_q.cnt == '0)
    else $error("clear left a nonzero count");

  a_latch_copy: assert property (accept |=> s_q.lat == $past(s_q.cnt))
    else $error("latch differs from counters");

  a_busy_fixed: assert property (accept && BUFFERED |=> s_busy_win)
    else $error("busy shorter than one microsecond");

  a_busy_refuse: assert property (s_q.busy_cnt != 4'h0 || s_q.full |-> !accept)
    else $error("trigger taken while busy");

  a_full_busy: assert property (s_q.full |-> s_q.busy && buffer_full)
    else $error("full without busy");

  a_ready_set: assert property (accept && BUFFERED |=> s_q.ready && data_ready_line_oe)
    else $error("ready not raised after event");

  a_step_rate: assert property (tmr_step |=> s_step_gap)
    else $error("timer step not every four cycles");

  a_bus_answer: assert property (acc_phase && !s_q.rsp.pready |=> s_q.rsp.pready)
    else $error("bus answer late");

endmodule

// file: include/lsc_pkg.sv
// Constants, types and bus carriers of the latching scaler
package lsc_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_NS        = 100;
  localparam int unsigned BUSY_BUF_NS   = 1000;
  localparam int unsigned BUSY_UNBUF_NS = 150;
  localparam int unsigned STEP_NS       = 400;
  localparam int unsigned LED_INIT_MS   = 200;
  localparam int unsigned LED_ACC_MS    = 50;
  localparam logic [3:0]  BUSY_BUF_CYC  = 4'((BUSY_BUF_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0]  BUSY_UNBUF_CYC = 4'((BUSY_UNBUF_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [1:0]  STEP_LAST     = 2'((STEP_NS / CLK_NS) - 1);
  localparam int unsigned LED_INIT_CYC  = LED_INIT_MS * 1_000_000 / CLK_NS;
  localparam int unsigned LED_ACC_CYC   = LED_ACC_MS * 1_000_000 / CLK_NS;

  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int unsigned NUM_CH    = 32;
  localparam int unsigned BUF_WORDS = 32768;

  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [15:0] OFS_BUF    = 16'h0000;
  localparam logic [8:0]  OFS_CNT_PG = 9'h020;
  localparam logic [15:0] OFS_CHEN   = 16'h1100;
  localparam logic [15:0] OFS_DWELL  = 16'h1104;
  localparam logic [15:0] OFS_CTRL   = 16'h1108;
  localparam logic [15:0] OFS_STAT   = 16'h110C;
  localparam logic [15:0] OFS_SWTRG  = 16'h1110;
  localparam logic [15:0] OFS_SWCLR  = 16'h1114;
  localparam logic [15:0] OFS_FILL   = 16'h1118;
  localparam logic [15:0] OFS_TRGNUM = 16'h111C;

  // ----------------------------------------
  // Fields and reset values
  // ----------------------------------------
  localparam int unsigned CTRL_CLRBUF = 6;
  localparam int unsigned HDR_ID      = 26;
  localparam logic [31:0] CHEN_RST    = 32'hFFFF_FFFF;
  localparam logic [31:0] DWELL_RST   = 32'h0000_0000;

  typedef enum logic [1:0] {
    ACQ_OFF      = 2'b00,
    ACQ_RANDOM   = 2'b01,
    ACQ_PERIODIC = 2'b10
  } lsc_acq_t;

  typedef enum logic [1:0] {
    SRC_EXT   = 2'b00,
    SRC_TIMER = 2'b01,
    SRC_BUS   = 2'b10
  } lsc_src_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata;
  } lsc_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } lsc_apb_rsp_t;

endpackage

// file: tb/lsc_chain_peer.sv
// Neighbour module on the daisy-chained wired-OR control bus
`timescale 1ns/1ns
module lsc_chain_peer
  import lsc_pkg::*;
(
  // Neighbour activity
  input  logic peer_busy,
  input  logic peer_ready,
  // Local module drivers
  input  logic busy_o,
  input  logic busy_oe,
  input  logic ready_o,
  input  logic ready_oe,
  // Shared lines
  output logic busy_line,
  output logic ready_line
);
  // ----------------------------------------
  // Wired-OR lines
  // ----------------------------------------
  // A released driver adds nothing; any driver pulls the line high
  assign busy_line  = (busy_oe & busy_o) | peer_busy;
  assign ready_line = (ready_oe & ready_o) | peer_ready;
endmodule

// file: tb/tb_latching_scaler_control.sv
// Self-checking testbench of the latching scaler core
`timescale 1ns/1ns
module tb_latching_scaler_control
  import lsc_pkg::*;
;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  localparam int unsigned LED_ACC = 4;
  logic              sys_clk;
  logic              rst;
  lsc_apb_req_t      req;
  lsc_apb_rsp_t      rsp;
  logic [NUM_CH-1:0] ch;
  logic              tst, clr, inh, trf, trb, peer_busy, peer_ready;
  logic              rdy_o, rdy_oe, bsy_o, bsy_oe, busy_line, ready_line;
  logic              full, l_acc, l_rdy, l_bsy, l_full;
  logic [31:0]       r;
  logic              e;
  int                n;
  int                n2;
  logic              bsy2;
  int                fail_count;
  int                tests_run;

  lsc_top #(.BUFFERED(1'b1), .EVENT_WORDS(256), .LED_INIT_CYCLES(8),
            .LED_ACCESS_CYCLES(LED_ACC)) uut (
    .sys_clk(sys_clk), .rst(rst), .apb_req(req), .apb_rsp(rsp),
    .channel_in(ch), .test_in(tst), .counter_clear_input(clr),
    .count_inhibit_input(inh), .trigger_input_front(trf), .trigger_input_bus(trb),
    .data_ready_line_i(ready_line), .data_ready_line_o(rdy_o), .data_ready_line_oe(rdy_oe),
    .busy_line_i(busy_line), .busy_line_o(bsy_o), .busy_line_oe(bsy_oe),
    .buffer_full(full), .led_access(l_acc), .led_ready(l_rdy), .led_busy(l_bsy),
    .led_full(l_full));

  lsc_chain_peer peer (
    .peer_busy(peer_busy), .peer_ready(peer_ready), .busy_o(bsy_o), .busy_oe(bsy_oe),
    .ready_o(rdy_o), .ready_oe(rdy_oe), .busy_line(busy_line), .ready_line(ready_line));

  // Unbuffered variant shares bus and inputs; only its busy is watched
  lsc_top #(.BUFFERED(1'b0), .EVENT_WORDS(256), .LED_INIT_CYCLES(8),
            .LED_ACCESS_CYCLES(LED_ACC)) uut_unbuf (
    .sys_clk(sys_clk), .rst(rst), .apb_req(req), .apb_rsp(),
    .channel_in(ch), .test_in(tst), .counter_clear_input(clr),
    .count_inhibit_input(inh), .trigger_input_front(trf), .trigger_input_bus(trb),
    .data_ready_line_i(ready_line), .data_ready_line_o(), .data_ready_line_oe(),
    .busy_line_i(busy_line), .busy_line_o(bsy2), .busy_line_oe(),
    .buffer_full(), .led_access(), .led_ready(), .led_busy(), .led_full());

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
  endtask

  // Holds the request until pready is sampled high
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge sys_clk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge sys_clk);
    req.penable <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      k++;
    end
    while (rsp.pready !== 1'b1 && k < 20);
    r = rsp.prdata;
    e = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    if (k >= 20)
    begin
      fail_count++;
      give_verdict();
    end
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] m, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(r & m, x);
  endtask

  task automatic pulse(input logic [NUM_CH-1:0] m, input int k);
    repeat (k)
    begin
      @(posedge sys_clk);
      ch <= m;
      @(posedge sys_clk);
      ch <= '0;
    end
  endtask

  task automatic clear_pulse;
    @(posedge sys_clk);
    clr <= 1'b1;
    @(posedge sys_clk);
    clr <= 1'b0;
  endtask

  task automatic trig_ext;
    @(posedge sys_clk);
    trf <= 1'b1;
    tick(2);
    trf <= 1'b0;
  endtask

  // Bounded wait for local busy to drop
  task automatic wait_idle;
    int k;
    k = 0;
    tick(2);
    while (bsy_o !== 1'b0 && k < 40)
    begin
      @(posedge sys_clk);
      k++;
    end
    if (k >= 40)
    begin
      fail_count++;
      give_verdict();
    end
  endtask

  task automatic to_rise(output int c);
    c = 0;
    while (bsy_o !== 1'b0 && c < 60)
    begin
      @(posedge sys_clk);
      c++;
    end
    while (bsy_o !== 1'b1 && c < 60)
    begin
      @(posedge sys_clk);
      c++;
    end
  endtask

  // ----------------------------------------
  // Clock and main sequence
  // ----------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  initial
  begin
    req = '0; ch = '0; tst = 0; clr = 0; inh = 0; trf = 0; trb = 0;
    peer_busy = 0; peer_ready = 0; rst = 1; fail_count = 0; tests_run = 0;
    tick(12);
    rst <= 1'b0;
    tick(2);
    chk({l_acc, l_rdy, l_bsy, l_full}, 32'hF);           // Lamps lit at start
    tick(10);
    chk({l_bsy, l_full}, 32'h0);                         // Lamps settle
    rd(OFS_CHEN, '1, CHEN_RST);                          // Enable reset
    rd(OFS_DWELL, '1, DWELL_RST);                        // Dwell reset
    rd(OFS_CTRL, 32'h3, 32'h0);                          // Triggers off
    chk(l_acc, 32'h1);                                   // Access lamp
    pulse(32'h1, 3);
    pulse(32'h20, 1);
    @(posedge sys_clk) tst <= 1'b1;
    @(posedge sys_clk) tst <= 1'b0;
    @(posedge sys_clk) inh <= 1'b1;
    pulse('1, 2);
    @(posedge sys_clk) inh <= 1'b0;
    apb(1'b1, OFS_CTRL, 32'h1);                          // Random mode
    apb(1'b1, OFS_CHEN, 32'h21);                         // Two channels stored
    trig_ext();                                          // Front trigger
    n = 0;
    n2 = 0;
    for (int i = 0; i < 25; i++)
    begin
      @(posedge sys_clk);
      if (bsy_o === 1'b1)
        n++;
      if (bsy2 === 1'b1 && i < 5)
        n2++;
      if (i == 3)
        trb <= 1'b1;
      if (i == 5)
        trb <= 1'b0;
    end
    chk(n, 32'hA);                                       // Busy length
    chk(n2, 32'h2);                                      // Unbuffered busy
    rd(OFS_FILL, '1, 32'h1);                             // Late trigger dropped
    rd(16'h1000, '1, 32'h4);                             // Edges plus
    rd(16'h1014, '1, 32'h2);                             // Inhibited edges lost
    rd(16'h107C, '1, 32'h1);                             // Top channel
    rd(OFS_STAT, 32'h1, 32'h1);                          // Ready status
    chk(rdy_o & rdy_oe, 32'h1);                          // Ready driven
    rd(OFS_BUF, 32'h07FF_0000, 32'h0408_0000);           // Header
    rd(OFS_BUF, '1, 32'h4);                              // First word
    rd(OFS_BUF, '1, 32'h2);                              // Second word
    pulse(32'h1, 1);
    @(posedge sys_clk) trb <= 1'b1;
    @(posedge sys_clk) trb <= 1'b0;
    wait_idle();
    rd(16'h1000, '1, 32'h5);                             // Bus-side trigger
    pulse(32'h1, 1);
    apb(1'b1, OFS_SWTRG, 32'h0);
    wait_idle();
    rd(16'h1000, '1, 32'h6);                             // Software trigger
    apb(1'b1, OFS_CTRL, 32'h41);
    clear_pulse();
    rd(OFS_STAT, 32'h1, 32'h0);                          // Buffer emptied
    rd(OFS_FILL, '1, 32'h0);                             // No rows left
    peer_busy <= 1'b1;
    peer_ready <= 1'b1;
    rd(OFS_STAT, 32'h1F, 32'h18);                        // Shared lines sensed
    apb(1'b1, OFS_SWTRG, 32'h0);
    wait_idle();
    rd(16'h1000, '1, 32'h0);                             // Cleared, peer busy ignored
    peer_busy <= 1'b0;
    peer_ready <= 1'b0;
    clear_pulse();
    repeat (7)
    begin
      apb(1'b1, OFS_SWTRG, 32'h0);
      wait_idle();
    end
    apb(1'b1, OFS_SWTRG, 32'h0);
    tick(15);
    chk({full, bsy_o, bsy_oe, l_full}, 32'hF);           // Full holds busy
    rd(OFS_STAT, 32'h6, 32'h6);                          // Full status
    pulse(32'h1, 1);
    apb(1'b1, OFS_SWTRG, 32'h0);
    tick(3);
    rd(OFS_FILL, '1, 32'h8);                             // Buffer size
    rd(16'h1000, '1, 32'h0);                             // No latch while full
    clear_pulse();
    wait_idle();
    chk(full, 32'h0);                                    // Full drops
    apb(1'b1, OFS_DWELL, 32'h3);                         // Period above busy
    apb(1'b1, OFS_CTRL, 32'h42);                         // Periodic mode
    to_rise(n);
    to_rise(n);
    chk(n, 32'hC);                                       // Three 400 ns steps
    apb(1'b1, OFS_CTRL, 32'h40);
    wait_idle();
    trig_ext();
    tick(3);
    chk(bsy_o, 32'h0);                                   // Disabled mode
    apb(1'b0, 16'h2000, 32'h0);
    chk(r, 32'h0);                                       // Unmapped reads zero
    chk(e, 32'h1);                                       // Unmapped refused
    tick(LED_ACC + 3);
    chk(l_acc, 32'h0);                                   // Access lamp ends
    give_verdict();
  end
endmodule
